// ---- logic/pdr_dialer.sv ----
`timescale 1ns/1ps

module pdr_dialer #(
   parameter int OSC_DIV       = pdr_pkg::OSC_DIV_CYC,
   parameter int FAST_HALF_CYC = pdr_pkg::FAST_HALF_CYC
) (
   input  wire logic       I_CORE_CLK,
   input  wire logic       I_RESET_N,
   input  wire logic [3:0] I_ROW,
   input  wire logic [2:0] I_COL,
   input  wire logic       I_HOOK_LINE,
   input  wire logic       I_RATE_SELECT,
   input  wire logic       I_RATIO_SELECT,
   input  wire logic       I_MUTE,
   input  wire logic       I_PULSE,
   output logic [3:0]      O_ROW,
   output logic [3:0]      O_ROW_OE_N,
   output logic [2:0]      O_COL,
   output logic [2:0]      O_COL_OE_N,
   output logic            O_MUTE,
   output logic            O_MUTE_OE_N,
   output logic            O_PULSE,
   output logic            O_PULSE_OE_N,
   output logic            O_TONE
);

   localparam int TW = pdr_pkg::TMR_W;

   // ***************************************************************
   // declarations
   // ***************************************************************
   pdr_pkg::pdr_pins_t  pins_raw;
   pdr_pkg::pdr_pins_t  pins_meta;
   pdr_pkg::pdr_pins_t  pins;
   pdr_pkg::pdr_keys_t  key_out;
   pdr_pkg::pdr_keys_t  key_oe_n;
   pdr_pkg::pdr_state_t state;
   pdr_pkg::pdr_state_t next_state;

   logic          hook_on;
   logic          osc_run;
   logic          osc_tick;
   logic          fast;
   logic          first_key;
   logic          key_enable;
   logic          key_wake;
   logic          key_strobe;
   logic          key_held;
   logic [3:0]    key_code;
   logic [TW-1:0] tmr;
   logic [TW-1:0] lim;
   logic          adv;
   logic          done;
   logic [3:0]    pulses_left;
   logic          digit_done;
   logic          more_after;
   logic          pending;
   logic [3:0]    mem [pdr_pkg::MEM_DEPTH];
   logic [5:0]    wr_ptr;
   logic [5:0]    rd_ptr;
   logic [3:0]    cur_digit;
   logic          is_redial;
   logic          mute_on;
   logic          tone;

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************

   // every pin passes two flops before any logic looks at it
   assign pins_raw = '{keys: '{row: I_ROW, col: I_COL},
                       hook_line: I_HOOK_LINE,
                       rate_select: I_RATE_SELECT,
                       ratio_select: I_RATIO_SELECT};

   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         pins_meta <= '1;
         pins      <= '1;
      end
      else
      begin
         pins_meta <= pins_raw;
         pins      <= pins_meta;
      end
   end

   // a floating hook pin is pulled high outside, so high is on-hook
   assign hook_on = pins.hook_line;

   // ***************************************************************
   // oscillator and keypad
   // ***************************************************************

   // oscillator only runs while dialling, during the reconnect burst, or while a key is being read
   assign osc_run = (state != pdr_pkg::ST_IDLE &&
                     state != pdr_pkg::ST_DEAD) ||
                    (state == pdr_pkg::ST_IDLE && key_wake);

   pdr_osc_div #(
      .DIV (OSC_DIV)
   ) u_osc (
      .i_clk   (I_CORE_CLK),
      .i_rst_n (I_RESET_N),
      .i_run   (osc_run),
      .i_half  (pins.rate_select),
      .o_tick  (osc_tick)
   );

   // keys are ignored on hook and during accelerated dialling
   assign key_enable = !hook_on && !fast &&
                       state != pdr_pkg::ST_DEAD;

   pdr_keypad u_keys (
      .i_clk       (I_CORE_CLK),
      .i_rst_n     (I_RESET_N),
      .i_tick      (osc_tick),
      .i_enable    (key_enable),
      .i_keys      (pins.keys),
      .o_keys      (key_out),
      .o_keys_oe_n (key_oe_n),
      .o_wake      (key_wake),
      .o_strobe    (key_strobe),
      .o_held      (key_held),
      .o_code      (key_code)
   );

   // ***************************************************************
   // digit memory
   // ***************************************************************

   assign is_redial = key_code == pdr_pkg::KEY_STAR ||
                      key_code == pdr_pkg::KEY_HASH;
   assign pending   = rd_ptr != wr_ptr;
   assign cur_digit = mem[rd_ptr[4:0]];

   // storage array, no reset needed beyond the pointers
   always_ff @(posedge I_CORE_CLK)
   begin
      if (key_strobe && !is_redial &&
          (first_key || wr_ptr < 6'(pdr_pkg::MEM_DEPTH)))
         mem[first_key ? 5'h0 : wr_ptr[4:0]] <= key_code;
   end

   // pointers: reset is the power-up clear of the stored number
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else if (key_strobe && first_key)
      begin
         rd_ptr <= '0;
         if (!is_redial)
            wr_ptr <= 6'h1;
      end
      else
      begin
         // later star/hash keys carry no digit and are dropped
         if (key_strobe && !is_redial &&
             wr_ptr < 6'(pdr_pkg::MEM_DEPTH))
            wr_ptr <= wr_ptr + 1'b1;
         if (digit_done)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end

   // first key after going off-hook decides redial or new number
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         first_key <= 1'b1;
      else if (state == pdr_pkg::ST_DEAD)
         first_key <= 1'b1;
      else if (key_strobe)
         first_key <= 1'b0;
   end

   // ***************************************************************
   // interval timer
   // ***************************************************************

   // interval length for the current state, in osc ticks except in fast mode
   always_comb
   begin
      case (state)
         pdr_pkg::ST_PAUSE:
            lim = TW'(pdr_pkg::DIGIT_GAP_TICKS);
         pdr_pkg::ST_BREAK:
            lim = pins.ratio_select ? TW'(pdr_pkg::BRK_HI_TICKS) :
                                      TW'(pdr_pkg::BRK_LO_TICKS);
         pdr_pkg::ST_MAKE:
            lim = pins.ratio_select ? TW'(pdr_pkg::MAKE_HI_TICKS) :
                                      TW'(pdr_pkg::MAKE_LO_TICKS);
         pdr_pkg::ST_OVERLAP,
         pdr_pkg::ST_RECON:
            lim = TW'(pdr_pkg::SILENCE_OVERLAP_TICKS);
         default:
            lim = TW'(1);
      endcase
      // accelerated: core cycles, equal halves, 100x the selected rate
      if (fast)
         lim = pins.rate_select ? TW'(FAST_HALF_CYC / 2) : TW'(FAST_HALF_CYC);
   end

   assign adv  = fast ? 1'b1 : osc_tick;
   assign done = adv && (tmr >= lim - 1'b1);

   // restart on every state change so each interval is whole
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         tmr <= '0;
      else if (next_state != state || done)
         tmr <= '0;
      else if (adv)
         tmr <= tmr + 1'b1;
   end

   // ***************************************************************
   // outpulsing sequencer
   // ***************************************************************

   assign more_after = (rd_ptr + 1'b1) != wr_ptr;
   assign digit_done = state == pdr_pkg::ST_BREAK && done &&
                       pulses_left <= 4'h1;

   always_comb
   begin
      next_state = state;
      case (state)
         pdr_pkg::ST_IDLE:
            if (hook_on)
               next_state = pdr_pkg::ST_DEAD;
            else if (pending)
               next_state = pdr_pkg::ST_PAUSE;
         pdr_pkg::ST_PAUSE:
            if (done)
               next_state = pdr_pkg::ST_BREAK;
         pdr_pkg::ST_BREAK:
            if (done)
               if (pulses_left > 4'h1)
                  next_state = pdr_pkg::ST_MAKE;
               else if (more_after)
                  next_state = pdr_pkg::ST_PAUSE;
               else
                  next_state = pdr_pkg::ST_OVERLAP;
         pdr_pkg::ST_MAKE:
            if (done)
               next_state = pdr_pkg::ST_BREAK;
         pdr_pkg::ST_OVERLAP:
            if (done)
               if (fast || hook_on)
                  next_state = pdr_pkg::ST_DEAD;
               else if (pending)
                  next_state = pdr_pkg::ST_PAUSE;
               else
                  next_state = pdr_pkg::ST_IDLE;
         pdr_pkg::ST_RECON:
            if (hook_on)
               next_state = pdr_pkg::ST_DEAD;
            else if (done)
               next_state = pdr_pkg::ST_IDLE;
         pdr_pkg::ST_DEAD:
            if (!hook_on)
               next_state = pdr_pkg::ST_RECON;
         default:
            next_state = pdr_pkg::ST_DEAD;
      endcase
   end

   // power-up lands in the quiet state until the hook is read
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         state <= pdr_pkg::ST_DEAD;
      else
         state <= next_state;
   end

   // break count: digit n gives n breaks, zero is coded as ten
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         pulses_left <= '0;
      else if (state == pdr_pkg::ST_PAUSE && done)
         pulses_left <= cur_digit;
      else if (state == pdr_pkg::ST_BREAK && done)
         pulses_left <= pulses_left - 1'b1;
   end

   // on-hook mid-dial latches fast mode until fully shut down
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         fast <= 1'b0;
      else if (state == pdr_pkg::ST_DEAD)
         fast <= 1'b0;
      else if (hook_on && (state == pdr_pkg::ST_PAUSE ||
                           state == pdr_pkg::ST_BREAK ||
                           state == pdr_pkg::ST_MAKE))
         fast <= 1'b1;
   end

   // ***************************************************************
   // outputs
   // ***************************************************************

   // mute spans the pause, the pulses and the overlap; the short
   // reconnect burst gives the falling edge on leaving on-hook
   assign mute_on = state == pdr_pkg::ST_PAUSE ||
                    state == pdr_pkg::ST_BREAK ||
                    state == pdr_pkg::ST_MAKE ||
                    state == pdr_pkg::ST_OVERLAP ||
                    state == pdr_pkg::ST_RECON;

   // open-drain pins only ever pull low, enable active low
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         O_MUTE       <= 1'b0;
         O_MUTE_OE_N  <= 1'b1;
         O_PULSE      <= 1'b0;
         O_PULSE_OE_N <= 1'b1;
      end
      else
      begin
         O_MUTE       <= 1'b0;
         O_MUTE_OE_N  <= !mute_on;
         O_PULSE      <= 1'b0;
         O_PULSE_OE_N <= state != pdr_pkg::ST_BREAK;
      end
   end

   // tone toggles per tick: 1.2 kHz at 10 pps, doubles at 20 pps
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         tone <= 1'b0;
      else if (!key_held)
         tone <= 1'b0;
      else if (osc_tick)
         tone <= !tone;
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         O_TONE <= 1'b0;
      else
         O_TONE <= tone;
   end

   // keypad drive already leaves flops inside the scanner
   assign O_ROW      = key_out.row;
   assign O_ROW_OE_N = key_oe_n.row;
   assign O_COL      = key_out.col;
   assign O_COL_OE_N = key_oe_n.col;

   // the pad readbacks are not needed: both pins only sink current
   logic unused_pads;
   assign unused_pads = I_MUTE ^ I_PULSE;

endmodule // pdr_dialer

// ---- logic/pdr_pkg.sv ----
package pdr_pkg;

   // ***************************************************************
   // base rates
   // ***************************************************************
   localparam int CORE_HZ      = 20_000_000;
   localparam int OSC_HZ       = 2400;
   localparam int OSC_DIV_CYC  = CORE_HZ / OSC_HZ;

   // ***************************************************************
   // dial timing, times in their own units, counts in osc ticks
   // ***************************************************************
   localparam int PULSE_PERIOD_MS = 100;
   localparam int PULSE_TICKS     = PULSE_PERIOD_MS * OSC_HZ / 1000;
   localparam int BRK_HI_PCT      = 66;
   localparam int BRK_LO_PCT      = 60;
   localparam int BRK_HI_TICKS    = PULSE_TICKS * BRK_HI_PCT / 100;
   localparam int MAKE_HI_TICKS   = PULSE_TICKS - BRK_HI_TICKS;
   localparam int BRK_LO_TICKS    = PULSE_TICKS * BRK_LO_PCT / 100;
   localparam int MAKE_LO_TICKS   = PULSE_TICKS - BRK_LO_TICKS;
   localparam int SILENCE_OVERLAP_MS    = 5;
   localparam int SILENCE_OVERLAP_TICKS = SILENCE_OVERLAP_MS * OSC_HZ / 1000;
   localparam int DIGIT_GAP_MS    = 800;
   localparam int DIGIT_GAP_TICKS = DIGIT_GAP_MS * OSC_HZ / 1000;
   localparam int KEY_VALID_MS    = 14;
   localparam int KEY_VALID_TICKS = (KEY_VALID_MS * OSC_HZ + 999) / 1000;
   // debounce is judged once per two-tick scan cycle
   localparam int KEY_VALID_SCANS = (KEY_VALID_TICKS + 1) / 2;
   // accelerated on-hook dialling: 100x rate, equal halves
   localparam int FAST_FACTOR     = 100;
   localparam int FAST_PERIOD_US  = PULSE_PERIOD_MS * 1000 / FAST_FACTOR;
   localparam int FAST_HALF_CYC   = FAST_PERIOD_US / 2 * (CORE_HZ / 1_000_000);
   localparam int TMR_W           = 16;

   // ***************************************************************
   // digit memory and key codes
   // ***************************************************************
   localparam int         MEM_DEPTH = 32;
   localparam logic [3:0] DIG_ZERO  = 4'ha;
   localparam logic [3:0] KEY_STAR  = 4'hb;
   localparam logic [3:0] KEY_HASH  = 4'hc;

   typedef struct packed {
      logic [3:0] row;
      logic [2:0] col;
   } pdr_keys_t;

   typedef struct packed {
      pdr_keys_t keys;
      logic      hook_line;
      logic      rate_select;
      logic      ratio_select;
   } pdr_pins_t;

   typedef enum logic [6:0] {
      ST_IDLE    = 7'h01,
      ST_PAUSE   = 7'h02,
      ST_BREAK   = 7'h04,
      ST_MAKE    = 7'h08,
      ST_OVERLAP = 7'h10,
      ST_RECON   = 7'h20,
      ST_DEAD    = 7'h40
   } pdr_state_t;

endpackage

// ---- logic/pdr_osc_div.sv ----
`timescale 1ns/1ps

// ***************************************************************
// gated stand-in for the on-chip rc oscillator
// ***************************************************************
module pdr_osc_div #(
   parameter int DIV = pdr_pkg::OSC_DIV_CYC
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_run,
   input  wire logic i_half,
   output logic      o_tick
);

   logic [pdr_pkg::TMR_W-1:0] cnt;
   logic [pdr_pkg::TMR_W-1:0] limit;

   // fast rate halves every derived interval at once
   assign limit = i_half ? pdr_pkg::TMR_W'(DIV / 2) : pdr_pkg::TMR_W'(DIV);

   // stopped oscillator restarts from zero, like a real start-up
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt    <= '0;
         o_tick <= 1'b0;
      end
      else if (!i_run)
      begin
         cnt    <= '0;
         o_tick <= 1'b0;
      end
      else if (cnt >= limit - 1'b1)
      begin
         cnt    <= '0;
         o_tick <= 1'b1;
      end
      else
      begin
         cnt    <= cnt + 1'b1;
         o_tick <= 1'b0;
      end
   end

endmodule // pdr_osc_div

// ---- logic/pdr_keypad.sv ----
`timescale 1ns/1ps

// ***************************************************************
// keypad scan, validity and debounce
// ***************************************************************
module pdr_keypad (
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   input  wire logic              i_tick,
   input  wire logic              i_enable,
   input  wire pdr_pkg::pdr_keys_t i_keys,
   output pdr_pkg::pdr_keys_t     o_keys,
   output pdr_pkg::pdr_keys_t     o_keys_oe_n,
   output logic                  o_wake,
   output logic                  o_strobe,
   output logic                  o_held,
   output logic [3:0]            o_code
);

   logic       scan;
   logic       phase;
   logic [2:0] col_lo;
   logic [3:0] row_lo;
   logic [4:0] stable;
   logic [3:0] last;
   logic       valid;
   logic [3:0] code;
   logic [1:0] ridx;
   logic [1:0] cidx;
   logic [1:0] settle;

   // exactly one row and one column pulled low
   assign valid = $onehot(row_lo) && $onehot(col_lo);

   // row/column position to digit code
   always_comb
   begin
      ridx = 2'h0;
      cidx = 2'h0;
      for (int i = 0; i < 4; i++)
         if (row_lo[i]) ridx = 2'(i);
      for (int j = 0; j < 3; j++)
         if (col_lo[j]) cidx = 2'(j);
      case (ridx)
         2'h3:    code = (cidx == 2'h0) ? pdr_pkg::KEY_STAR :
                         (cidx == 2'h1) ? pdr_pkg::DIG_ZERO :
                                          pdr_pkg::KEY_HASH;
         default: code = 4'(ridx * 3 + cidx + 1);
      endcase
   end

   // pin drive: held high on hook, static, then alternate scan
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_keys      <= '1;
         o_keys_oe_n <= '0;
      end
      else if (!i_enable)
      begin
         o_keys      <= '1;
         o_keys_oe_n <= '0;
      end
      else if (!scan || !phase)
      begin
         o_keys      <= '0;
         o_keys_oe_n <= '{row: 4'h0, col: 3'h7};
      end
      else
      begin
         o_keys      <= '0;
         o_keys_oe_n <= '{row: 4'hf, col: 3'h0};
      end
   end

   // scan sequencing and sampling, one tick per half cycle
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         scan   <= 1'b0;
         phase  <= 1'b0;
         settle <= '0;
         col_lo <= '0;
         row_lo <= '0;
      end
      else if (!i_enable)
      begin
         scan   <= 1'b0;
         phase  <= 1'b0;
         settle <= '0;
      end
      else if (!scan)
      begin
         // readback lags the drive by three flops: stale driven-low
         // columns would otherwise wake the scan again at once
         if (settle != 2'h3)
            settle <= settle + 1'b1;
         else
            scan <= (i_keys.col != 3'h7);
      end
      else if (i_tick)
      begin
         phase <= !phase;
         if (!phase)
            col_lo <= ~i_keys.col;
         else
            row_lo <= ~i_keys.row;
         // nothing pressed at all: fall back to the static state
         if (phase && i_keys.row == 4'hf && col_lo == 3'h0 && !o_held)
         begin
            scan   <= 1'b0;
            settle <= '0;
         end
      end
   end

   // debounce: same valid code for the whole window, once per press
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         stable   <= '0;
         last     <= '0;
         o_strobe <= 1'b0;
         o_held   <= 1'b0;
         o_code   <= '0;
      end
      else
      begin
         o_strobe <= 1'b0;
         if (!i_enable)
         begin
            stable <= '0;
            o_held <= 1'b0;
         end
         else if (scan && i_tick && !phase)
         begin
            if (valid && code == last)
            begin
               if (stable == 5'(pdr_pkg::KEY_VALID_SCANS - 1))
               begin
                  o_strobe <= !o_held;
                  o_held   <= 1'b1;
                  o_code   <= code;
               end
               else
                  stable <= stable + 1'b1;
            end
            else
            begin
               stable <= '0;
               last   <= code;
               o_held <= 1'b0;
            end
         end
      end
   end

   assign o_wake = scan;

endmodule // pdr_keypad

// ---- tb/pdr_dialer_chk.sv ----
`timescale 1ns/1ps
// ***
// dialer pin checks
// ***
module pdr_dialer_chk (
   input wire logic       I_CORE_CLK,
   input wire logic       I_RESET_N,
   input wire logic       I_HOOK_LINE,
   input wire logic [3:0] O_ROW,
   input wire logic [3:0] O_ROW_OE_N,
   input wire logic [2:0] O_COL,
   input wire logic [2:0] O_COL_OE_N,
   input wire logic       O_MUTE,
   input wire logic       O_MUTE_OE_N,
   input wire logic       O_PULSE,
   input wire logic       O_PULSE_OE_N
);
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RESET_N);
   // hook steady long enough to clear the synchroniser
   sequence s_hook_up;
      I_HOOK_LINE [*8];
   endsequence
   sequence s_off_hook;
      $fell(I_HOOK_LINE) ##1 !I_HOOK_LINE;
   endsequence
   // open-drain pads only ever pull low
   a_pulse_pad_low: assert property (O_PULSE == 1'h0)
      else $error("pulse pad high");
   a_mute_pad_low: assert property (O_MUTE == 1'h0)
      else $error("mute pad high");
   // mute brackets every break on both sides
   a_break_muted: assert property (!O_PULSE_OE_N |-> !O_MUTE_OE_N)
      else $error("break unmuted");
   a_pause_first: assert property ($fell(O_PULSE_OE_N) |->
      $past(O_MUTE_OE_N, 8) == 1'h0) else $error("no pause");
   a_mute_overlap: assert property ($rose(O_PULSE_OE_N) |->
      !O_MUTE_OE_N [*8]) else $error("mute dropped early");
   a_break_min: assert property ($fell(O_PULSE_OE_N) |->
      !O_PULSE_OE_N [*8]) else $error("break too short");
   // keypad parked on-hook, mute edge on lifting
   a_keys_parked: assert property (s_hook_up |-> O_ROW_OE_N == 4'h0 &&
      O_ROW == 4'hf && O_COL_OE_N == 3'h0 && O_COL == 3'h7)
      else $error("keypad not parked");
   a_offhook_mute: assert property (s_off_hook |-> ##[1:10] !O_MUTE_OE_N)
      else $error("no mute edge");
endmodule // pdr_dialer_chk

// ---- tb/pdr_far_model.sv ----
`timescale 1ns/1ps
// ***
// form-a keypad contact with pull-ups
// ***
module pdr_far_model (
   input  wire logic       i_on,
   input  wire logic [1:0] i_r,
   input  wire logic [1:0] i_c,
   input  wire logic [3:0] i_row,
   input  wire logic [3:0] i_roe,
   input  wire logic [2:0] i_col,
   input  wire logic [2:0] i_coe,
   output logic      [3:0] o_row,
   output logic      [2:0] o_col
);
   logic node;
   // released lines float up; a closed key ties its row and column
   always_comb
   begin
      o_row = i_row | i_roe;
      o_col = i_col | i_coe;
      node = o_row[i_r] & o_col[i_c];
      if (i_on)
      begin
         o_row[i_r] = node;
         o_col[i_c] = node;
      end
   end
endmodule // pdr_far_model

// ---- tb/pdr_dialer_tb.sv ----
`timescale 1ns/1ps
// ***
// dialer bench
// ***
module pdr_dialer_tb;
   localparam int TK = 10; // tick in clocks: div 20, halved at 20 pps
   logic       clk = 1'h0, rst_n = 1'h0, hook = 1'h1, ratio = 1'h1;
   logic       k_on = 1'h0, mo, moe, po, poe, tone, pm = 1'h1, first;
   logic       rate = 1'h1;
   logic [1:0] k_r = 2'h0, k_c = 2'h0;
   logic [3:0] ro, roe, ri;
   logic [2:0] co, coe, ci;
   int         err_count = 0, cmp_count = 0, nb = 0, len = 0, mk = 0;
   int         brk = 0, mkx = 0, d, i, q[$];
   always #25 clk = ~clk;
   pdr_dialer #(.OSC_DIV(20), .FAST_HALF_CYC(20)) dut_u (
      .I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_ROW(ri), .I_COL(ci),
      .I_HOOK_LINE(hook), .I_RATE_SELECT(rate), .I_RATIO_SELECT(ratio),
      .I_MUTE(moe | mo), .I_PULSE(poe | po), .O_ROW(ro), .O_ROW_OE_N(roe),
      .O_COL(co), .O_COL_OE_N(coe), .O_MUTE(mo), .O_MUTE_OE_N(moe),
      .O_PULSE(po), .O_PULSE_OE_N(poe), .O_TONE(tone));
   pdr_far_model far_u (.i_on(k_on), .i_r(k_r), .i_c(k_c), .i_row(ro),
      .i_roe(roe), .i_col(co), .i_coe(coe), .o_row(ri), .o_col(ci));
   task close_out;
      if (err_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (e !== s)
      begin
         err_count++;
         $display("BAD %s exp %0d seen %0d", n, e, s);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // hold a key, watch for the confirmation tone
   task press(input logic [1:0] r, input logic [1:0] c, input int h);
      int t;
      t = 0;
      k_r <= r;
      k_c <= c;
      k_on <= 1'h1;
      for (i = 0; i < h; i++)
      begin
         @(posedge clk);
         t += (tone === 1'h1);
      end
      k_on <= 1'h0;
      if (h > 400) chk("tone", 1, t > 0);
      tick(100);
   endtask
   // bounded wait until every call has been judged
   task drain;
      for (i = 0; i < 60000 && q.size() > 0; i++) @(posedge clk);
      chk("done", 0, q.size());
      if (err_count > 0) close_out();
   endtask
   // time breaks and makes, total breaks per muted stretch
   always @(posedge clk)
   if (rst_n)
   begin
      if (poe === 1'h0)
      begin
         if (mk > 0 && mkx > 0 && !first)
            chk("make", mk > 1500 ? pdr_pkg::DIGIT_GAP_TICKS * TK : mkx, mk);
         mk = 0;
         first = 1'h0;
         len++;
      end
      else
      begin
         if (len > 0) nb++;
         if (len > 0 && brk > 0) chk("break", brk, len);
         len = 0;
         mk += (moe === 1'h0);
      end
      if (moe === 1'h0 && pm === 1'h1) first = 1'h1;
      if (moe === 1'h1 && pm === 1'h0 && nb > 0)
      begin
         chk("breaks", q.pop_front(), nb);
         nb = 0;
      end
      pm = moe;
   end
   initial
   begin
      void'($urandom(32'h8ef8));
      d = 2 + $urandom % 2;
      tick(12);
      rst_n <= 1'h1;
      // new number at long break ratio
      hook <= 1'h0;
      tick(300);
      q.push_back(d + 1);
      brk = pdr_pkg::BRK_HI_TICKS * TK;
      mkx = pdr_pkg::MAKE_HI_TICKS * TK;
      press(2'h0, 2'(d - 1), 600);
      press(2'h0, 2'h0, 600);
      drain();
      // redial by star, hang up after the first break
      hook <= 1'h1;
      tick(7500);
      hook <= 1'h0;
      ratio <= 1'h0;
      brk = pdr_pkg::BRK_LO_TICKS * TK;
      mkx = pdr_pkg::MAKE_LO_TICKS * TK;
      tick(300);
      q.push_back(d + 1);
      press(2'h3, 2'h0, 600);
      for (i = 0; i < 30000 && nb == 0; i++) @(posedge clk);
      chk("redial break", 1, nb > 0);
      tick(100);
      hook <= 1'h1;
      brk = 0;
      mkx = 0;
      drain();
      // short glitch dropped, 9 then 0 replace memory, at 10 pps
      // the slower ticks need longer holds
      tick(7500);
      hook <= 1'h0;
      rate <= 1'h0;
      tick(300);
      q.push_back(19);
      press(2'h1, 2'h1, 200);
      press(2'h2, 2'h2, 900);
      press(2'h3, 2'h1, 900);
      hook <= 1'h1;
      drain();
      close_out();
   end
endmodule // pdr_dialer_tb

bind pdr_dialer pdr_dialer_chk chk_u (.I_CORE_CLK(I_CORE_CLK),
   .I_RESET_N(I_RESET_N), .I_HOOK_LINE(I_HOOK_LINE), .O_ROW(O_ROW),
   .O_ROW_OE_N(O_ROW_OE_N), .O_COL(O_COL), .O_COL_OE_N(O_COL_OE_N),
   .O_MUTE(O_MUTE), .O_MUTE_OE_N(O_MUTE_OE_N), .O_PULSE(O_PULSE),
   .O_PULSE_OE_N(O_PULSE_OE_N));
